// ==== cgr_regs.sv ====
/*
  APB register slice for codec gain and routing control: DAC input gain,
  sidetone gains, speaker gain, input and output routing bits.
  Assumes an APB master on CLK_SYS; the routing and gain outputs drive
  analog switches and gain stages elsewhere in the device.
*/
// Behaviour
// [R1] DAC codes 2,1,0 give -3,-1.5,0 dB
// [R2] Analog sidetone D5..D3: 111 mute, -27..-9 dB
// [R3] Digital sidetone D2..D0: 111 mute, -27..-9 dB
// [R4] Speaker gain D5..D4, 0..3 dB, reset 00
// [R5] Speaker D3..D0 reserved, read zero
// [R6] D6 loops headset input to output
// [R7] D5 loops handset input to output
// [R8] D4 routes caller ID to ADC
// [R9] D3 routes line input to ADC
// [R10] D2 routes microphone to ADC
// [R11] D1 routes handset input to ADC
// [R12] D0 routes headset input to ADC
// [R13] Output routing D7=1, D6 reserved read-only
// [R14] Top write bits pick the sub-register
// [R15] Readback returns fields; settings hold until rewritten
`timescale 1ns/1ps
`default_nettype none

module cgr_regs
  import cgr_pkg::*;
(
  input wire logic CLK_SYS, // 250 MHz clock
  input wire logic RESET_N, // Async reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB unmapped address
  output logic [5:0] DAC_GAIN_CODE, // DAC input gain code
  output logic [7:0] DAC_ATTEN, // DAC attenuation, half dB
  output logic [2:0] ANALOG_SIDETONE_GAIN, // Analog sidetone code
  output logic [7:0] ANALOG_SIDETONE_ATTEN, // Half-dB attenuation
  output logic ANALOG_SIDETONE_MUTE, // Analog sidetone muted
  output logic [2:0] DIGITAL_SIDETONE_GAIN, // Digital sidetone code
  output logic [7:0] DIGITAL_SIDETONE_ATTEN, // Half-dB attenuation
  output logic DIGITAL_SIDETONE_MUTE, // Digital sidetone muted
  output logic [1:0] SPEAKER_GAIN, // Speaker gain, dB
  output logic HEADSET_IN_TO_OUT, // Headset loop closed
  output logic HANDSET_IN_TO_OUT, // Handset loop closed
  output logic CALLER_ID_TO_ADC, // Caller ID to ADC
  output logic LINE_IN_TO_ADC, // Line input to ADC
  output logic MICROPHONE_TO_ADC, // Microphone to ADC
  output logic HANDSET_TO_ADC, // Handset input to ADC
  output logic HEADSET_TO_ADC, // Headset input to ADC
  output logic ANALOG_SIDETONE_TO_HEADSET, // Sidetone to headset
  output logic ANALOG_SIDETONE_TO_HANDSET, // Sidetone to handset
  output logic SPEAKER_OUT_EN, // DAC to speaker driver
  output logic LINE_OUT_EN, // DAC to line driver
  output logic HANDSET_OUT_EN, // DAC to handset driver
  output logic HEADSET_OUT_EN // DAC to headset driver
);

  cgr_apb_e state;
  logic [5:0] dac_gain;
  logic [2:0] analog_sidetone_gain;
  logic [2:0] digital_sidetone_gain;
  logic [1:0] speaker_gain;
  logic [6:0] in_route;
  logic [5:0] out_route;
  logic last5_speaker;
  logic last6_out;
  logic setup;
  logic wr_en;
  logic [7:0] wbyte;
  logic [5:0] dec_code [NDEC];
  logic [7:0] dec_base [NDEC];
  logic [7:0] dec_step [NDEC];
  logic dec_mute_en [NDEC];
  logic [7:0] dec_atten [NDEC];
  logic dec_mute [NDEC];

  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      OFS_SHARED5, OFS_SHARED6, OFS_SIDETONE, OFS_SPEAKER,
      OFS_IN_ROUTE, OFS_OUT_ROUTE, OFS_DAC_GAIN: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic [7:0] st_byte(input logic [2:0] ast,
                                         input logic [2:0] dst);
    st_byte = 8'h00;
    st_byte[SEL_HI:SEL_LO] = SEL_SIDETONE;
    st_byte[AST_LO +: 3] = ast;
    st_byte[DST_LO +: 3] = dst;
  endfunction : st_byte

  function automatic logic [7:0] spk_byte(input logic [1:0] spk);
    spk_byte = 8'h00;
    spk_byte[SEL_HI:SEL_LO] = SEL_SPEAKER;
    spk_byte[SPK_LO +: 2] = spk;
  endfunction : spk_byte

  function automatic logic [7:0] in_byte(input logic [6:0] r);
    in_byte = {SEL_IN_ROUTE, r};
  endfunction : in_byte

  function automatic logic [7:0] out_byte(input logic [5:0] r);
    out_byte = {SEL_OUT_ROUTE, 1'b0, r};
  endfunction : out_byte

  assign setup = PSEL && !PENABLE;
  // Write lands only at the edge where the access completes
  assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
  assign wbyte = PWDATA[7:0];

  // APB handshake: one setup, one access cycle, no wait states
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state <= CGR_IDLE;
    end
    else
    begin
      case (state)
        CGR_IDLE:
        begin
          if (setup)
          begin
            state <= CGR_ACCESS;
          end
        end
        CGR_ACCESS:
        begin
          state <= CGR_IDLE;
        end
        default:
        begin
          state <= CGR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else if (state == CGR_IDLE && setup)
    begin
      PREADY <= 1'b1;
      PSLVERR <= !is_mapped(PADDR);
    end
    else
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // [R15] Field readback
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PRDATA <= 32'h0000_0000;
    end
    else if (state == CGR_IDLE && setup && !PWRITE)
    begin
      case (PADDR)
        OFS_SHARED5:
          PRDATA <= {24'h00_0000, last5_speaker ? spk_byte(speaker_gain)
                     : st_byte(analog_sidetone_gain,
                               digital_sidetone_gain)};
        OFS_SHARED6:
          PRDATA <= {24'h00_0000, last6_out ? out_byte(out_route)
                     : in_byte(in_route)};
        OFS_SIDETONE:
          PRDATA <= {24'h00_0000,
                     st_byte(analog_sidetone_gain, digital_sidetone_gain)};
        // [R5] Reserved bits read zero
        OFS_SPEAKER: PRDATA <= {24'h00_0000, spk_byte(speaker_gain)};
        OFS_IN_ROUTE: PRDATA <= {24'h00_0000, in_byte(in_route)};
        OFS_OUT_ROUTE: PRDATA <= {24'h00_0000, out_byte(out_route)};
        OFS_DAC_GAIN: PRDATA <= {24'h00_0000, 2'h0, dac_gain};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
    else
    begin
      PRDATA <= 32'h0000_0000;
    end
  end

  // [R1] DAC input gain code
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      dac_gain <= DAC_RST;
    end
    else if (wr_en && PADDR == OFS_DAC_GAIN)
    begin
      dac_gain <= wbyte[DAC_W-1:0];
    end
  end

  // [R14] Shared address picks sidetone or speaker
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      analog_sidetone_gain <= AST_RST;
      digital_sidetone_gain <= DST_RST;
      last5_speaker <= 1'b0;
    end
    else if (wr_en && ((PADDR == OFS_SHARED5 &&
             wbyte[SEL_HI:SEL_LO] == SEL_SIDETONE) ||
             PADDR == OFS_SIDETONE))
    begin
      // [R2] Analog sidetone field
      analog_sidetone_gain <= wbyte[AST_LO +: 3];
      // [R3] Digital sidetone field
      digital_sidetone_gain <= wbyte[DST_LO +: 3];
      if (PADDR == OFS_SHARED5)
      begin
        last5_speaker <= 1'b0;
      end
    end
    else if (wr_en && PADDR == OFS_SHARED5 &&
             wbyte[SEL_HI:SEL_LO] == SEL_SPEAKER)
    begin
      last5_speaker <= 1'b1;
    end
  end

  // [R4] Speaker gain; reserved low bits dropped
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      speaker_gain <= SPK_RST;
    end
    else if (wr_en && ((PADDR == OFS_SHARED5 &&
             wbyte[SEL_HI:SEL_LO] == SEL_SPEAKER) ||
             PADDR == OFS_SPEAKER))
    begin
      speaker_gain <= wbyte[SPK_LO +: 2];
    end
  end

  // [R14] D7 picks input or output routing
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      in_route <= IN_ROUTE_RST;
      out_route <= OUT_ROUTE_RST;
      last6_out <= 1'b0;
    end
    else if (wr_en)
    begin
      if ((PADDR == OFS_SHARED6 && wbyte[SEL_HI] == SEL_IN_ROUTE) ||
          PADDR == OFS_IN_ROUTE)
      begin
        // [R6] [R7] [R8] [R9] [R10] [R11] [R12] Routing bits
        in_route <= wbyte[ROUTE_IN_W-1:0];
      end
      if ((PADDR == OFS_SHARED6 && wbyte[SEL_HI] == SEL_OUT_ROUTE) ||
          PADDR == OFS_OUT_ROUTE)
      begin
        // [R13] D6 reserved, not stored
        out_route <= wbyte[ROUTE_OUT_W-1:0];
      end
      if (PADDR == OFS_SHARED6)
      begin
        last6_out <= wbyte[SEL_HI];
      end
    end
  end

  // Decoder inputs per gain path
  always_comb
  begin
    dec_code[DEC_DAC] = dac_gain;
    dec_base[DEC_DAC] = DAC_BASE;
    dec_step[DEC_DAC] = DAC_STEP;
    dec_mute_en[DEC_DAC] = 1'b0;
    dec_code[DEC_AST] = {3'h0, analog_sidetone_gain};
    dec_base[DEC_AST] = STG_BASE;
    dec_step[DEC_AST] = STG_STEP;
    dec_mute_en[DEC_AST] = 1'b1;
    dec_code[DEC_DST] = {3'h0, digital_sidetone_gain};
    dec_base[DEC_DST] = STG_BASE;
    dec_step[DEC_DST] = STG_STEP;
    dec_mute_en[DEC_DST] = 1'b1;
  end

  generate
    for (genvar g = 0; g < NDEC; g++)
    begin : g_dec
      cgr_gain_dec u_dec (
        .code(dec_code[g]),
        .base(dec_base[g]),
        .step(dec_step[g]),
        .mute_en(dec_mute_en[g]),
        .mute_code(STG_MUTE),
        .atten(dec_atten[g]),
        .mute(dec_mute[g])
      );
    end
  endgenerate

  // Decoded figures registered so outputs stay glitch-free
  // [R1] DAC attenuation 1.5 dB per code
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      DAC_ATTEN <= DAC_BASE;
    end
    else
    begin
      DAC_ATTEN <= dec_atten[DEC_DAC];
    end
  end

  // [R2] [R3] Sidetone attenuation and mute
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ANALOG_SIDETONE_ATTEN <= STG_BASE;
      ANALOG_SIDETONE_MUTE <= 1'b0;
      DIGITAL_SIDETONE_ATTEN <= STG_BASE;
      DIGITAL_SIDETONE_MUTE <= 1'b0;
    end
    else
    begin
      ANALOG_SIDETONE_ATTEN <= dec_atten[DEC_AST];
      ANALOG_SIDETONE_MUTE <= dec_mute[DEC_AST];
      DIGITAL_SIDETONE_ATTEN <= dec_atten[DEC_DST];
      DIGITAL_SIDETONE_MUTE <= dec_mute[DEC_DST];
    end
  end

  // Control outputs come straight from the stored fields
  assign DAC_GAIN_CODE = dac_gain;
  assign ANALOG_SIDETONE_GAIN = analog_sidetone_gain;
  assign DIGITAL_SIDETONE_GAIN = digital_sidetone_gain;
  assign SPEAKER_GAIN = speaker_gain;
  assign {HEADSET_IN_TO_OUT, HANDSET_IN_TO_OUT, CALLER_ID_TO_ADC,
          LINE_IN_TO_ADC, MICROPHONE_TO_ADC, HANDSET_TO_ADC,
          HEADSET_TO_ADC} = in_route;
  assign {ANALOG_SIDETONE_TO_HEADSET, ANALOG_SIDETONE_TO_HANDSET,
          SPEAKER_OUT_EN, LINE_OUT_EN, HANDSET_OUT_EN,
          HEADSET_OUT_EN} = out_route;

endmodule : cgr_regs

`default_nettype wire

// ==== cgr_pkg.sv ====
/*
  Constants for the codec gain and routing register slice: APB offsets,
  field positions, sub-register selectors, reset values, decode figures.
  Assumes a 32-bit APB with byte addresses and aligned word registers.
*/
package cgr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Byte offsets of the word registers
  localparam logic [11:0] OFS_SHARED5 = 12'h000;
  localparam logic [11:0] OFS_SHARED6 = 12'h004;
  localparam logic [11:0] OFS_SIDETONE = 12'h008;
  localparam logic [11:0] OFS_SPEAKER = 12'h00c;
  localparam logic [11:0] OFS_IN_ROUTE = 12'h010;
  localparam logic [11:0] OFS_OUT_ROUTE = 12'h014;
  localparam logic [11:0] OFS_DAC_GAIN = 12'h018;

  // Selector bits in D7..D6 of a shared sidetone or speaker write, D7 alone of a shared routing write
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam logic [1:0] SEL_SIDETONE = 2'h2;
  localparam logic [1:0] SEL_SPEAKER = 2'h3;
  localparam logic SEL_IN_ROUTE = 1'h0;
  localparam logic SEL_OUT_ROUTE = 1'h1;

  // Field positions
  localparam int AST_LO = 3;
  localparam int DST_LO = 0;
  localparam int SPK_LO = 4;
  localparam int ROUTE_IN_W = 7;
  localparam int ROUTE_OUT_W = 6;
  localparam int DAC_W = 6;

  // Reset values
  localparam logic [2:0] AST_RST = 3'h0;
  localparam logic [2:0] DST_RST = 3'h0;
  localparam logic [1:0] SPK_RST = 2'h0;
  localparam logic [6:0] IN_ROUTE_RST = 7'h00;
  localparam logic [5:0] OUT_ROUTE_RST = 6'h00;
  localparam logic [5:0] DAC_RST = 6'h00;

  // Gain decode, in half-dB attenuation steps
  localparam int NDEC = 3;
  localparam int DEC_DAC = 0;
  localparam int DEC_AST = 1;
  localparam int DEC_DST = 2;
  localparam logic [7:0] DAC_BASE = 8'h00;
  localparam logic [7:0] DAC_STEP = 8'h03;
  localparam logic [7:0] STG_BASE = 8'h12;
  localparam logic [7:0] STG_STEP = 8'h06;
  localparam logic [5:0] STG_MUTE = 6'h07;

  typedef enum logic [1:0] {
    CGR_IDLE = 2'b01,
    CGR_ACCESS = 2'b10
  } cgr_apb_e;

endpackage : cgr_pkg

// ==== cgr_gain_dec.sv ====
/*
  Gain code decoder: attenuation = base + step * code, in half dB,
  with an optional mute code. Purely combinational; the caller registers.
*/
`timescale 1ns/1ps
`default_nettype none

module cgr_gain_dec
  import cgr_pkg::*;
(
  input wire logic [5:0] code, // Gain code
  input wire logic [7:0] base, // Attenuation at code 0
  input wire logic [7:0] step, // Attenuation per code
  input wire logic mute_en, // Mute code exists
  input wire logic [5:0] mute_code, // Code that mutes
  output logic [7:0] atten, // Half-dB attenuation
  output logic mute // Path muted
);

  logic [13:0] prod;

  always_comb
  begin
    prod = step * {2'h0, code};
    mute = mute_en && (code == mute_code);
    // Muted paths report zero so no stale figure leaks out
    if (mute)
    begin
      atten = 8'h00;
    end
    else
    begin
      atten = 8'(base + prod[7:0]);
    end
  end

endmodule : cgr_gain_dec

`default_nettype wire

// ==== cgr_regs_sva.sv ====
/*
  Checker for the codec gain and routing register slice.
  Assumes it is bound to cgr_regs; port names match the design's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module cgr_regs_sva
  import cgr_pkg::*;
(
  input wire logic CLK_SYS, // Clock
  input wire logic RESET_N, // Async reset
  input wire logic PSEL, // Select
  input wire logic PENABLE, // Access
  input wire logic PWRITE, // Direction
  input wire logic [11:0] PADDR, // Address
  input wire logic [31:0] PRDATA, // Read data
  input wire logic PREADY, // Ready
  input wire logic [5:0] DAC_GAIN_CODE, // DAC code
  input wire logic [7:0] DAC_ATTEN, // DAC attenuation
  input wire logic [2:0] ANALOG_SIDETONE_GAIN, // Code
  input wire logic [7:0] ANALOG_SIDETONE_ATTEN, // Attenuation
  input wire logic ANALOG_SIDETONE_MUTE, // Mute
  input wire logic [2:0] DIGITAL_SIDETONE_GAIN, // Code
  input wire logic [7:0] DIGITAL_SIDETONE_ATTEN, // Attenuation
  input wire logic DIGITAL_SIDETONE_MUTE, // Mute
  input wire logic [1:0] SPEAKER_GAIN, // Speaker gain
  input wire logic HEADSET_IN_TO_OUT, // Loop
  input wire logic HANDSET_IN_TO_OUT, // Loop
  input wire logic CALLER_ID_TO_ADC, // Route
  input wire logic LINE_IN_TO_ADC, // Route
  input wire logic MICROPHONE_TO_ADC, // Route
  input wire logic HANDSET_TO_ADC, // Route
  input wire logic HEADSET_TO_ADC // Route
);
  logic rd_cyc;
  logic [6:0] rin;

  assign rd_cyc = PSEL && PENABLE && PREADY && !PWRITE;
  assign rin = {HEADSET_IN_TO_OUT, HANDSET_IN_TO_OUT, CALLER_ID_TO_ADC,
    LINE_IN_TO_ADC, MICROPHONE_TO_ADC, HANDSET_TO_ADC, HEADSET_TO_ADC};

  function automatic logic [7:0] stg(input logic [2:0] c);
    return c == 3'h7 ? 8'h00 : 8'h12 + 8'h06 * {5'h00, c};
  endfunction : stg

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  AST_READY_NEXT: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("No ready after setup");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("Ready longer than one cycle");
  AST_ANA_GAIN: assert property (1'b1 |=>
    ANALOG_SIDETONE_MUTE == ($past(ANALOG_SIDETONE_GAIN) == 3'h7) &&
    ANALOG_SIDETONE_ATTEN == stg($past(ANALOG_SIDETONE_GAIN)))
    else $error("Analog sidetone decode wrong");
  AST_DIG_GAIN: assert property (1'b1 |=>
    DIGITAL_SIDETONE_MUTE == ($past(DIGITAL_SIDETONE_GAIN) == 3'h7) &&
    DIGITAL_SIDETONE_ATTEN == stg($past(DIGITAL_SIDETONE_GAIN)))
    else $error("Digital sidetone decode wrong");
  AST_DAC_ATTEN: assert property (1'b1 |=>
    DAC_ATTEN == 8'h03 * {2'h0, $past(DAC_GAIN_CODE)})
    else $error("DAC attenuation wrong");
  AST_SPK_READ: assert property (rd_cyc && PADDR == OFS_SPEAKER |->
    PRDATA == {24'h000000, 2'h3, SPEAKER_GAIN, 4'h0})
    else $error("Speaker readback wrong");
  AST_IN_READ: assert property (rd_cyc && PADDR == OFS_IN_ROUTE |->
    PRDATA == {25'h0000000, rin})
    else $error("Input routing readback wrong");
  AST_ROUTE_HOLD: assert property (!(PSEL && PENABLE && PWRITE) |=>
    $stable(rin) && $stable(SPEAKER_GAIN))
    else $error("Setting changed without a write");

  cover property (rd_cyc && PADDR == OFS_IN_ROUTE);
  cover property (ANALOG_SIDETONE_MUTE && DIGITAL_SIDETONE_GAIN == 3'h0);
  cover property (SPEAKER_GAIN == 2'h3);
  cover property (rd_cyc && PADDR == OFS_SHARED5);

endmodule : cgr_regs_sva

bind cgr_regs cgr_regs_sva u_cgr_sva (.*);

`default_nettype wire

// ==== testbench.sv ====
/*
  Self-checking bench for the codec gain and routing register slice.
  Assumes an APB slave on clk that answers within 16 cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench
  import cgr_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, am, dm;
  wire logic [5:0] dac_code, rout;
  wire logic [7:0] dac_att, aat, dat;
  wire logic [2:0] ag, dg;
  wire logic [1:0] spk;
  wire logic [6:0] rin;
  int n_errors = 0;
  int compares = 0;
  int i;
  logic [31:0] rd;
  logic er;
  logic [2:0] c;
  logic [6:0] v;
  logic [5:0] u, d6;

  always #2 clk = ~clk;

  cgr_regs dut (
    .CLK_SYS(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .DAC_GAIN_CODE(dac_code),
    .DAC_ATTEN(dac_att), .ANALOG_SIDETONE_GAIN(ag),
    .ANALOG_SIDETONE_ATTEN(aat), .ANALOG_SIDETONE_MUTE(am),
    .DIGITAL_SIDETONE_GAIN(dg), .DIGITAL_SIDETONE_ATTEN(dat),
    .DIGITAL_SIDETONE_MUTE(dm), .SPEAKER_GAIN(spk),
    .HEADSET_IN_TO_OUT(rin[6]), .HANDSET_IN_TO_OUT(rin[5]),
    .CALLER_ID_TO_ADC(rin[4]), .LINE_IN_TO_ADC(rin[3]),
    .MICROPHONE_TO_ADC(rin[2]), .HANDSET_TO_ADC(rin[1]),
    .HEADSET_TO_ADC(rin[0]), .ANALOG_SIDETONE_TO_HEADSET(rout[5]),
    .ANALOG_SIDETONE_TO_HANDSET(rout[4]), .SPEAKER_OUT_EN(rout[3]),
    .LINE_OUT_EN(rout[2]), .HANDSET_OUT_EN(rout[1]),
    .HEADSET_OUT_EN(rout[0])
  );

  function automatic logic [7:0] stg(input logic [2:0] k);
    return k == 3'h7 ? 8'h00 : 8'h12 + 8'h06 * {5'h00, k};
  endfunction : stg

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until ready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      n_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask : apb

  task automatic reset_check();
    chk("route_rst", 32'h0, {17'h0, spk, rout, rin});
    chk("att_rst", 32'h00121200, {8'h0, aat, dat, dac_att});
  endtask : reset_check

  task automatic complete_run();
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'he9e3));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    reset_check();
    apb(1'b0, OFS_OUT_ROUTE, 32'h0);
    chk("out_rd", 32'h80, rd);
    for (i = 0; i < 8; i++)
    begin
      c = i[2:0];
      apb(1'b1, OFS_SHARED5, {24'h0, 2'h2, c, ~c});
      @(negedge clk);
      chk("ast", {20'h0, c == 3'h7, stg(c), c},
        {20'h0, am, aat, ag});
      chk("dst", {20'h0, ~c == 3'h7, stg(~c), ~c},
        {20'h0, dm, dat, dg});
      apb(1'b0, OFS_SIDETONE, 32'h0);
      chk("st_rd", {24'h0, 2'h2, c, ~c}, rd);
    end
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, OFS_SHARED5, {24'h0, 2'h3, i[1:0], 4'hf});
      apb(1'b0, OFS_SPEAKER, 32'h0);
      chk("spk", {22'h0, 2'h3, i[1:0], 4'h0, i[1:0]},
        {22'h0, rd[7:0], spk});
    end
    // View write leaves the shared pick on speaker
    apb(1'b1, OFS_SPEAKER, 32'h2f);
    apb(1'b0, OFS_SHARED5, 32'h0);
    chk("sh5_rd", 32'he0, rd);
    // Unknown selector must not disturb the sidetone store
    apb(1'b1, OFS_SIDETONE, 32'h0d);
    apb(1'b1, OFS_SHARED5, 32'h40);
    apb(1'b0, OFS_SIDETONE, 32'h0);
    chk("st_keep", 32'h8d, rd);
    for (i = 0; i < 16; i++)
    begin
      v = (i < 7) ? 7'h01 << i : 7'($urandom);
      u = 6'($urandom);
      apb(1'b1, OFS_SHARED6, {25'h0, v});
      apb(1'b1, OFS_SHARED6, {24'h0, 2'h3, u});
      apb(1'b0, OFS_IN_ROUTE, 32'h0);
      chk("in_rt", {17'h0, 1'b0, v, v},
        {17'h0, rd[7:0], rin});
      apb(1'b0, OFS_OUT_ROUTE, 32'h0);
      chk("out_rt", {18'h0, 2'h2, u, u}, {18'h0, rd[7:0], rout});
    end
    apb(1'b0, OFS_SHARED6, 32'h0);
    chk("sh6_rd", {24'h0, 2'h2, u}, rd);
    for (i = 0; i < 8; i++)
    begin
      d6 = (i < 3) ? i[5:0] : 6'($urandom);
      apb(1'b1, OFS_DAC_GAIN, {26'h0, d6});
      @(negedge clk);
      chk("dac", {18'h0, d6, 8'h03 * {2'h0, d6}},
        {18'h0, dac_code, dac_att});
    end
    apb(1'b0, OFS_DAC_GAIN, 32'h0);
    chk("dac_rd", {26'h0, d6}, rd);
    apb(1'b1, 12'h100, 32'h7f);
    chk("err", 32'h1, {31'h0, er});
    chk("keep", {25'h0, v}, {25'h0, rin});
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    reset_check();
    apb(1'b0, OFS_SHARED5, 32'h0);
    chk("sh5_rst", 32'h80, rd);
    apb(1'b0, OFS_SHARED6, 32'h0);
    chk("sh6_rst", 32'h0, rd);
    complete_run();
  end

endmodule : testbench

`default_nettype wire
